// ===== include/codec_ctrl_map.vh
// Offsets, field positions, reset values and encodings of the codec control bank
`ifndef CODEC_CTRL_MAP_VH
`define CODEC_CTRL_MAP_VH

// ****************************************
// Index addresses
// ****************************************
`define IDX_LEFT_ADC 4'h0
`define IDX_RIGHT_ADC 4'h1
`define IDX_LEFT_AUX_ONE 4'h2
`define IDX_RIGHT_AUX_ONE 4'h3
`define IDX_LEFT_AUX_TWO 4'h4
`define IDX_RIGHT_AUX_TWO 4'h5
`define IDX_LEFT_DAC 4'h6
`define IDX_RIGHT_DAC 4'h7
`define IDX_FORMAT 4'h8
`define IDX_IFACE_CFG 4'h9
`define IDX_PIN_CTRL 4'ha
`define IDX_INVALID_A 4'hb
`define IDX_MISC_INFO 4'hc
`define IDX_DIGITAL_MIX 4'hd
`define IDX_INVALID_B 4'he
`define IDX_INVALID_C 4'hf

// ****************************************
// Reset values
// ****************************************
`define RST_ADC_CTRL 8'h00
`define RST_AUX_CTRL 8'h80
`define RST_DAC_CTRL 8'h80
`define RST_FORMAT 8'h00

// ****************************************
// Writable bit masks (reserved bits held at zero)
// ****************************************
`define MASK_ADC_CTRL 8'hcf
`define MASK_AUX_CTRL 8'h9f
`define MASK_DAC_CTRL 8'hbf
`define MASK_FORMAT 8'h7f

// ****************************************
// Control word layout (16 bits)
// ****************************************
`define CW_CLEAR_OVR_BIT 15
`define CW_MCE_BIT 14
`define CW_READ_REQ_BIT 13
`define CW_INDEX_MSB 11
`define CW_INDEX_LSB 8
`define CW_DATA_MSB 7
`define CW_DATA_LSB 0

// ****************************************
// Field positions
// ****************************************
`define ADC_GAIN_MSB 3
`define ADC_SRC_MSB 7
`define ADC_SRC_LSB 6
`define AUX_GAIN_MSB 4
`define MUTE_BIT 7
`define DAC_ATTEN_MSB 5
`define FMT_CLK_SRC_BIT 0
`define FMT_DIV_MSB 3
`define FMT_DIV_LSB 1
`define FMT_STEREO_BIT 4
`define FMT_COMPAND_BIT 5
`define FMT_VARIANT_BIT 6

// ****************************************
// Encodings
// ****************************************
`define SRC_LINE_ONE 2'h0
`define SRC_AUX_ONE 2'h1
`define SRC_LINE_TWO 2'h2
`define SRC_LOOPBACK 2'h3
`define ENC_LINEAR_U8 2'h0
`define ENC_LINEAR_S16 2'h1
`define ENC_MULAW 2'h2
`define ENC_ALAW 2'h3

// ****************************************
// Sample-rate divide factors
// ****************************************
`define DIV_CODE0 12'd3072
`define DIV_CODE1 12'd1536
`define DIV_CODE2 12'd896
`define DIV_CODE3 12'd768
`define DIV_CODE4 12'd448
`define DIV_CODE5 12'd384
`define DIV_CODE6 12'd512
`define DIV_CODE7 12'd2560

`endif

// ===== src/ctrl_reg8.v
// One 8-bit indexed control register with masked write and reset value
module ctrl_reg8 #(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hff
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Write port
    input wire wr_en,
    input wire [7:0] wr_data,
    // Stored value
    output reg [7:0] value_r
);

    always @(posedge clk) begin
        if (rst) begin
            value_r <= RESET_VALUE;
        end else if (wr_en) begin
            value_r <= wr_data & WRITE_MASK;
        end
    end

endmodule // ctrl_reg8

// ===== src/rate_divider.v
// Divides a crystal clock enable into a sample-rate enable pulse
`include "codec_ctrl_map.vh"
module rate_divider (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Crystal tick and divide code
    input wire xtal_tick,
    input wire [2:0] div_sel,
    // Sample-rate pulse
    output reg sample_tick_r
);

    reg [11:0] factor;
    reg [11:0] count_r;

    always @* begin
        case (div_sel)
            3'h0: factor = `DIV_CODE0;
            3'h1: factor = `DIV_CODE1;
            3'h2: factor = `DIV_CODE2;
            3'h3: factor = `DIV_CODE3;
            3'h4: factor = `DIV_CODE4;
            3'h5: factor = `DIV_CODE5;
            3'h6: factor = `DIV_CODE6;
            3'h7: factor = `DIV_CODE7;
            default: factor = `DIV_CODE0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            count_r <= 12'h000;
            sample_tick_r <= 1'b0;
        end else begin
            sample_tick_r <= 1'b0;
            if (xtal_tick) begin
                if (count_r >= factor - 12'h001) begin
                    count_r <= 12'h000;
                    sample_tick_r <= 1'b1;
                end else begin
                    count_r <= count_r + 12'h001;
                end
            end
        end
    end

endmodule // rate_divider

// ===== src/codec_indirect_control_regs.v
// Indirectly addressed control register bank of a serial stereo codec
`include "codec_ctrl_map.vh"
module codec_indirect_control_regs (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Received control word, valid for one cycle when complete
    input wire ctrl_word_valid,
    input wire [15:0] ctrl_word,
    // Status word returned on reads of invalid or unhandled indices
    input wire [15:0] status_word,
    // Crystal tick enables (internal or overdriven)
    input wire primary_crystal_input,
    input wire secondary_crystal_input,
    // Readback word for the next status slot
    output reg [15:0] readback_word_r,
    output reg readback_valid_r,
    // Mode change state
    output reg mode_change_enable_r,
    // ADC input control
    output reg [3:0] left_adc_gain,
    output reg [3:0] right_adc_gain,
    output reg [1:0] left_source_sel,
    output reg [1:0] right_source_sel,
    // Auxiliary input control
    output reg [4:0] left_aux_one_gain,
    output reg [4:0] right_aux_one_gain,
    output reg [4:0] left_aux_two_gain,
    output reg [4:0] right_aux_two_gain,
    output reg left_aux_one_mute,
    output reg right_aux_one_mute,
    output reg left_aux_two_mute,
    output reg right_aux_two_mute,
    // DAC control
    output reg [5:0] left_dac_atten,
    output reg [5:0] right_dac_atten,
    output reg left_dac_mute,
    output reg right_dac_mute,
    // Data format
    output reg rate_clock_source_sel,
    output reg [2:0] rate_divide_sel,
    output reg stereo_mode,
    output reg [1:0] sample_encoding,
    output reg sample_tick
);

    // ****************************************
    // Control word decode
    // ****************************************
    wire [3:0] index_address = ctrl_word[`CW_INDEX_MSB:`CW_INDEX_LSB];
    wire [7:0] wr_byte = ctrl_word[`CW_DATA_MSB:`CW_DATA_LSB];
    wire mce_bit = ctrl_word[`CW_MCE_BIT];
    wire read_req = ctrl_word[`CW_READ_REQ_BIT];
    reg [8:0] wr_sel;
    reg index_valid;

    always @* begin
        wr_sel = 9'h000;
        index_valid = 1'b1;
        case (index_address)
            `IDX_INVALID_A, `IDX_INVALID_B, `IDX_INVALID_C: index_valid = 1'b0;
            default: index_valid = 1'b1;
        endcase
        if (ctrl_word_valid && index_address <= `IDX_FORMAT) begin
            wr_sel[index_address] = 1'b1;
        end
        // Format register is protected
        if (!mce_bit) begin
            wr_sel[8] = 1'b0;
        end
    end

    // ****************************************
    // Register bank
    // ****************************************
    wire [7:0] regs [0:8];
    wire [7:0] left_adc_input_ctrl = regs[0];
    wire [7:0] right_adc_input_ctrl = regs[1];
    wire [7:0] left_aux_one_ctrl = regs[2];
    wire [7:0] right_aux_one_ctrl = regs[3];
    wire [7:0] left_aux_two_ctrl = regs[4];
    wire [7:0] right_aux_two_ctrl = regs[5];
    wire [7:0] left_dac_level_ctrl = regs[6];
    wire [7:0] right_dac_level_ctrl = regs[7];
    wire [7:0] sample_format_ctrl = regs[8];

    ctrl_reg8 #(
        .RESET_VALUE(`RST_ADC_CTRL),
        .WRITE_MASK(`MASK_ADC_CTRL)
    ) u_left_adc (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[0]),
        .wr_data(wr_byte),
        .value_r(regs[0])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_ADC_CTRL),
        .WRITE_MASK(`MASK_ADC_CTRL)
    ) u_right_adc (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[1]),
        .wr_data(wr_byte),
        .value_r(regs[1])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_AUX_CTRL),
        .WRITE_MASK(`MASK_AUX_CTRL)
    ) u_left_aux1 (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[2]),
        .wr_data(wr_byte),
        .value_r(regs[2])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_AUX_CTRL),
        .WRITE_MASK(`MASK_AUX_CTRL)
    ) u_right_aux1 (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[3]),
        .wr_data(wr_byte),
        .value_r(regs[3])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_AUX_CTRL),
        .WRITE_MASK(`MASK_AUX_CTRL)
    ) u_left_aux2 (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[4]),
        .wr_data(wr_byte),
        .value_r(regs[4])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_AUX_CTRL),
        .WRITE_MASK(`MASK_AUX_CTRL)
    ) u_right_aux2 (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[5]),
        .wr_data(wr_byte),
        .value_r(regs[5])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_DAC_CTRL),
        .WRITE_MASK(`MASK_DAC_CTRL)
    ) u_left_dac (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[6]),
        .wr_data(wr_byte),
        .value_r(regs[6])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_DAC_CTRL),
        .WRITE_MASK(`MASK_DAC_CTRL)
    ) u_right_dac (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[7]),
        .wr_data(wr_byte),
        .value_r(regs[7])
    );
    ctrl_reg8 #(
        .RESET_VALUE(`RST_FORMAT),
        .WRITE_MASK(`MASK_FORMAT)
    ) u_format (
        .clk(clk),
        .rst(rst),
        .wr_en(wr_sel[8]),
        .wr_data(wr_byte),
        .value_r(regs[8])
    );

    // ****************************************
    // Mode change state and readback
    // ****************************************
    reg [7:0] read_byte;

    always @* begin
        case (index_address)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: read_byte = regs[index_address];
            default: read_byte = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            mode_change_enable_r <= 1'b1;
            readback_word_r <= 16'h0000;
            readback_valid_r <= 1'b0;
        end else begin
            readback_valid_r <= ctrl_word_valid;
            if (ctrl_word_valid) begin
                mode_change_enable_r <= mce_bit;
                if (read_req && index_valid && index_address <= `IDX_FORMAT) begin
                    readback_word_r <= {ctrl_word[15:13], 1'b0, index_address, read_byte};
                end else begin
                    readback_word_r <= status_word;
                end
            end
        end
    end

    // ****************************************
    // Crystal selection and sample-rate divider
    // ****************************************
    reg xtal_tick_r;

    always @(posedge clk) begin
        if (rst) begin
            xtal_tick_r <= 1'b0;
        end else begin
            // Overdriven external clocks arrive as the same tick
            xtal_tick_r <= sample_format_ctrl[`FMT_CLK_SRC_BIT] ?
                secondary_crystal_input : primary_crystal_input;
        end
    end

    wire sample_tick_w;

    rate_divider u_rate_divider (
        .clk(clk),
        .rst(rst),
        .xtal_tick(xtal_tick_r),
        .div_sel(sample_format_ctrl[`FMT_DIV_MSB:`FMT_DIV_LSB]),
        .sample_tick_r(sample_tick_w)
    );

    // ****************************************
    // Field outputs
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            left_adc_gain <= 4'h0;
            right_adc_gain <= 4'h0;
            left_source_sel <= `SRC_LINE_ONE;
            right_source_sel <= `SRC_LINE_ONE;
            left_aux_one_gain <= 5'h00;
            right_aux_one_gain <= 5'h00;
            left_aux_two_gain <= 5'h00;
            right_aux_two_gain <= 5'h00;
            left_aux_one_mute <= 1'b1;
            right_aux_one_mute <= 1'b1;
            left_aux_two_mute <= 1'b1;
            right_aux_two_mute <= 1'b1;
            left_dac_atten <= 6'h00;
            right_dac_atten <= 6'h00;
            left_dac_mute <= 1'b1;
            right_dac_mute <= 1'b1;
            rate_clock_source_sel <= 1'b0;
            rate_divide_sel <= 3'h0;
            stereo_mode <= 1'b0;
            sample_encoding <= `ENC_LINEAR_U8;
            sample_tick <= 1'b0;
        end else begin
            left_adc_gain <= left_adc_input_ctrl[`ADC_GAIN_MSB:0];
            right_adc_gain <= right_adc_input_ctrl[`ADC_GAIN_MSB:0];
            left_source_sel <= left_adc_input_ctrl[`ADC_SRC_MSB:`ADC_SRC_LSB];
            right_source_sel <= right_adc_input_ctrl[`ADC_SRC_MSB:`ADC_SRC_LSB];
            left_aux_one_gain <= left_aux_one_ctrl[`AUX_GAIN_MSB:0];
            right_aux_one_gain <= right_aux_one_ctrl[`AUX_GAIN_MSB:0];
            left_aux_two_gain <= left_aux_two_ctrl[`AUX_GAIN_MSB:0];
            right_aux_two_gain <= right_aux_two_ctrl[`AUX_GAIN_MSB:0];
            left_aux_one_mute <= left_aux_one_ctrl[`MUTE_BIT];
            right_aux_one_mute <= right_aux_one_ctrl[`MUTE_BIT];
            left_aux_two_mute <= left_aux_two_ctrl[`MUTE_BIT];
            right_aux_two_mute <= right_aux_two_ctrl[`MUTE_BIT];
            left_dac_atten <= left_dac_level_ctrl[`DAC_ATTEN_MSB:0];
            right_dac_atten <= right_dac_level_ctrl[`DAC_ATTEN_MSB:0];
            // DAC muted by its own bit or by mode change state
            left_dac_mute <= left_dac_level_ctrl[`MUTE_BIT] | mode_change_enable_r;
            right_dac_mute <= right_dac_level_ctrl[`MUTE_BIT] | mode_change_enable_r;
            rate_clock_source_sel <= sample_format_ctrl[`FMT_CLK_SRC_BIT];
            rate_divide_sel <= sample_format_ctrl[`FMT_DIV_MSB:`FMT_DIV_LSB];
            stereo_mode <= sample_format_ctrl[`FMT_STEREO_BIT];
            sample_encoding <= {sample_format_ctrl[`FMT_COMPAND_BIT],
                sample_format_ctrl[`FMT_VARIANT_BIT]};
            sample_tick <= sample_tick_w;
        end
    end

endmodule // codec_indirect_control_regs

// ===== verification/codec_regs_props.sv
// Port checks for the codec control register bank
module codec_regs_props (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control word side
    input wire ctrl_word_valid,
    input wire [15:0] ctrl_word,
    input wire [15:0] status_word,
    input wire [15:0] readback_word_r,
    input wire readback_valid_r,
    input wire mode_change_enable_r,
    // Register fields
    input wire [3:0] left_adc_gain,
    input wire [1:0] left_source_sel,
    input wire [4:0] left_aux_one_gain,
    input wire left_aux_one_mute,
    input wire left_dac_mute,
    input wire right_dac_mute,
    input wire rate_clock_source_sel,
    input wire [2:0] rate_divide_sel,
    input wire stereo_mode,
    input wire [1:0] sample_encoding,
    input wire sample_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [3:0] idx = ctrl_word[11:8];
    wire fmt_wr = ctrl_word_valid && idx == 4'h8 && ctrl_word[14];
    a_rb_follows_word: assert property (ctrl_word_valid |=> readback_valid_r)
        else $error("readback strobe missing after control word");
    a_rb_no_spurious: assert property (!ctrl_word_valid |=> !readback_valid_r)
        else $error("readback strobe without control word");
    a_rb_status_word: assert property (ctrl_word_valid && !ctrl_word[13]
        |=> readback_word_r == $past(status_word)) else $error("status word not returned");
    a_rb_index_echo: assert property (ctrl_word_valid && ctrl_word[13] && idx <= 4'h8
        |=> readback_word_r[15:8] == {$past(ctrl_word[15:13]), 1'b0, $past(idx)})
        else $error("readback header does not echo control word");
    a_invalid_status: assert property (ctrl_word_valid && ctrl_word[13]
        && (idx == 4'hb || idx >= 4'he) |=> readback_word_r == $past(status_word))
        else $error("invalid index read did not return status");
    a_mce_tracks: assert property (ctrl_word_valid
        |=> mode_change_enable_r == $past(ctrl_word[14])) else $error("mode change state wrong");
    a_dac_mce_mute: assert property (mode_change_enable_r
        |=> left_dac_mute && right_dac_mute) else $error("dac not muted in mode change");
    a_fmt_locked: assert property (!fmt_wr |-> ##2
        $stable({rate_clock_source_sel, rate_divide_sel, stereo_mode, sample_encoding}))
        else $error("format changed without enabled write");
    a_aux_write: assert property (ctrl_word_valid && idx == 4'h2 |-> ##2
        {left_aux_one_mute, left_aux_one_gain} == {$past(ctrl_word[7], 2), $past(ctrl_word[4:0], 2)})
        else $error("aux field not written");
    a_adc_write: assert property (ctrl_word_valid && idx == 4'h0 |-> ##2
        {left_source_sel, left_adc_gain} == {$past(ctrl_word[7:6], 2), $past(ctrl_word[3:0], 2)})
        else $error("adc field not written");
    a_tick_single: assert property (sample_tick |=> !sample_tick)
        else $error("sample tick longer than one cycle");
endmodule // codec_regs_props
bind codec_indirect_control_regs codec_regs_props i_codec_regs_props (.clk(clk), .rst(rst),
    .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word), .status_word(status_word),
    .readback_word_r(readback_word_r), .readback_valid_r(readback_valid_r),
    .mode_change_enable_r(mode_change_enable_r), .left_adc_gain(left_adc_gain),
    .left_source_sel(left_source_sel), .left_aux_one_gain(left_aux_one_gain),
    .left_aux_one_mute(left_aux_one_mute), .left_dac_mute(left_dac_mute),
    .right_dac_mute(right_dac_mute), .rate_clock_source_sel(rate_clock_source_sel),
    .rate_divide_sel(rate_divide_sel), .stereo_mode(stereo_mode),
    .sample_encoding(sample_encoding), .sample_tick(sample_tick));

// ===== verification/host_ctrl_model.sv
// Host model that hands complete control words to the bank
module host_ctrl_model (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Requests from the bench
    input wire req,
    input wire [15:0] req_word,
    // Word to the bank
    output reg ctrl_word_valid,
    output reg [15:0] ctrl_word
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk) begin
        if (rst) begin
            ctrl_word_valid <= 1'b0;
            ctrl_word <= 16'h0000;
        end else if (req) begin
            ctrl_word_valid <= 1'b1;
            ctrl_word <= req_word;
        end else begin
            ctrl_word_valid <= 1'b0;
            ctrl_word <= ~ctrl_word;
        end
    end
endmodule // host_ctrl_model

// ===== verification/tb_top.sv
// Self-checking bench for the codec control register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [95:0] FACS = {12'd2560, 12'd512, 12'd384, 12'd448, 12'd768, 12'd896, 12'd1536,
        12'd3072};
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg req = 1'b0;
    reg [15:0] req_word = 16'h0000;
    reg [15:0] status_word = 16'h005a; // Arbitrary status pattern
    reg primary_tick = 1'b0;
    reg secondary_tick = 1'b1;
    integer fail_count = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i;
    reg [7:0] rv;
    wire ctrl_word_valid, readback_valid_r, mode_change_enable_r, sample_tick;
    wire [15:0] ctrl_word, readback_word_r;
    wire [3:0] left_adc_gain, right_adc_gain;
    wire [1:0] left_source_sel, right_source_sel, sample_encoding;
    wire [4:0] left_aux_one_gain, right_aux_one_gain, left_aux_two_gain, right_aux_two_gain;
    wire left_aux_one_mute, right_aux_one_mute, left_aux_two_mute, right_aux_two_mute;
    wire [5:0] left_dac_atten, right_dac_atten;
    wire left_dac_mute, right_dac_mute, rate_clock_source_sel, stereo_mode;
    wire [2:0] rate_divide_sel;
    wire [13:0] dac_view = {left_dac_mute, left_dac_atten, right_dac_mute, right_dac_atten};
    wire [6:0] fmt_view = {rate_clock_source_sel, rate_divide_sel, stereo_mode, sample_encoding};
    host_ctrl_model i_host_ctrl_model (.clk(clk), .rst(rst), .req(req), .req_word(req_word),
        .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word));
    codec_indirect_control_regs i_codec_indirect_control_regs (.clk(clk), .rst(rst),
        .ctrl_word_valid(ctrl_word_valid), .ctrl_word(ctrl_word), .status_word(status_word),
        .primary_crystal_input(primary_tick), .secondary_crystal_input(secondary_tick),
        .readback_word_r(readback_word_r), .readback_valid_r(readback_valid_r),
        .mode_change_enable_r(mode_change_enable_r), .left_adc_gain(left_adc_gain),
        .right_adc_gain(right_adc_gain), .left_source_sel(left_source_sel),
        .right_source_sel(right_source_sel), .left_aux_one_gain(left_aux_one_gain),
        .right_aux_one_gain(right_aux_one_gain), .left_aux_two_gain(left_aux_two_gain),
        .right_aux_two_gain(right_aux_two_gain), .left_aux_one_mute(left_aux_one_mute),
        .right_aux_one_mute(right_aux_one_mute), .left_aux_two_mute(left_aux_two_mute),
        .right_aux_two_mute(right_aux_two_mute), .left_dac_atten(left_dac_atten),
        .right_dac_atten(right_dac_atten), .left_dac_mute(left_dac_mute),
        .right_dac_mute(right_dac_mute), .rate_clock_source_sel(rate_clock_source_sel),
        .rate_divide_sel(rate_divide_sel), .stereo_mode(stereo_mode),
        .sample_encoding(sample_encoding), .sample_tick(sample_tick));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        primary_tick <= ~primary_tick;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    // ********************************
    // Access tasks
    // ********************************
    task chk(input string what, input [23:0] exp, input [23:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    task send(input [15:0] w, output [15:0] rb);
        integer n;
        begin
            @(posedge clk);
            req <= 1'b1;
            req_word <= w;
            @(posedge clk);
            req <= 1'b0;
            n = 0;
            while (readback_valid_r !== 1'b1 && n < 8) begin
                @(posedge clk);
                n = n + 1;
            end
            rb = readback_word_r;
            chk("readback_valid_r", 24'h1, {23'h0, readback_valid_r});
            repeat (3) @(posedge clk);
        end
    endtask
    task wr(input mode_change_enable, input [3:0] ix, input [7:0] d);
        reg [15:0] rb;
        begin
            send({1'b0, mode_change_enable, 2'b00, ix, d}, rb);
            chk("status slot", {8'h0, status_word}, {8'h0, rb});
        end
    endtask
    task rd(input [3:0] ix, input [7:0] cur, input [15:0] exp);
        reg [15:0] rb;
        begin
            send({4'h6, ix, cur}, rb);
            chk("readback_word_r", {8'h0, exp}, {8'h0, rb});
        end
    endtask
    task period(input [11:0] exp);
        integer n;
        begin
            n = 0;
            while (sample_tick !== 1'b1 && n < 8000) begin
                @(posedge clk);
                n = n + 1;
            end
            @(posedge clk);
            n = 1;
            while (sample_tick !== 1'b1 && n < 8000) begin
                @(posedge clk);
                n = n + 1;
            end
            chk("sample period", {12'h0, exp}, n[23:0]);
        end
    endtask
    task complete_run;
        begin
            $display("compares %0d, fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    // ********************************
    // Tests
    // ********************************
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            rv = (i < 2 || i == 8) ? 8'h00 : 8'h80;
            rd(i[3:0], rv, {4'h6, i[3:0], rv});
        end
        chk("mutes", 24'h3f, {18'h0, left_aux_one_mute, right_aux_one_mute, left_aux_two_mute,
            right_aux_two_mute, left_dac_mute, right_dac_mute});
        $display("test reset_values done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(1'b1, 4'h0, {i[1:0], 2'b00, i[1:0], i[1:0]});
            chk("left adc", {18'h0, i[1:0], i[1:0], i[1:0]}, {18'h0, left_source_sel,
                left_adc_gain});
        end
        wr(1'b1, 4'h1, 8'hc5);
        chk("right adc", 24'h35, {18'h0, right_source_sel, right_adc_gain});
        $display("test adc_input done");
        wr(1'b1, 4'h2, 8'h1f);
        wr(1'b1, 4'h3, 8'h88);
        wr(1'b1, 4'h4, 8'h00);
        wr(1'b1, 4'h5, 8'h97);
        chk("aux", {6'h1f, 6'h28, 6'h00, 6'h37}, {left_aux_one_mute, left_aux_one_gain,
            right_aux_one_mute, right_aux_one_gain, left_aux_two_mute, left_aux_two_gain,
            right_aux_two_mute, right_aux_two_gain});
        wr(1'b1, 4'h6, 8'h3f);
        wr(1'b1, 4'h7, 8'h00);
        chk("dac in mode change", {10'h0, 1'b1, 6'h3f, 1'b1, 6'h00}, {10'h0, dac_view});
        wr(1'b0, 4'h7, 8'h00);
        chk("dac", {10'h0, 1'b0, 6'h3f, 1'b0, 6'h00}, {10'h0, dac_view});
        $display("test aux_dac done");
        wr(1'b0, 4'h8, 8'h7f);
        chk("format locked", 24'h0, {17'h0, fmt_view});
        for (i = 0; i < 4; i = i + 1) begin
            wr(1'b1, 4'h8, {1'b0, i[0], i[1], i[0], i[1:0], 1'b1, 1'b1});
            chk("format", {17'h0, 1'b1, i[1:0], 1'b1, i[0], i[1], i[0]},
                {17'h0, fmt_view});
        end
        for (i = 0; i < 8; i = i + 1) begin
            wr(1'b1, 4'h8, {4'h0, i[2:0], 1'b1});
            period(FACS[i*12 +: 12]);
        end
        wr(1'b1, 4'h8, 8'h06);
        period(12'd1536);
        $display("test data_format done");
        status_word <= 16'h0123;
        wr(1'b1, 4'hb, 8'h55);
        chk("alias", 24'h28, {18'h0, right_aux_one_mute, right_aux_one_gain});
        for (i = 9; i < 16; i = i + 1) begin
            rd(i[3:0], 8'h00, status_word);
        end
        $display("test invalid_index done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 8'h00, 16'h6000);
        rd(4'h3, 8'h80, 16'h6380);
        rd(4'h6, 8'h80, 16'h6680);
        rd(4'h8, 8'h00, 16'h6800);
        $display("test mid_reset done");
        complete_run;
    end
endmodule // tb_top
